//--- core/bit_fifo.sv
`timescale 1ns/1ns
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic        push;
  logic        pop;

  assign in_ready  = (st.count != (AW+1)'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data  = st.mem[st.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (rst)
    st.count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");

  fifo_full_a: assert property (@(posedge clk) disable iff (rst)
    (st.count == (AW+1)'(DEPTH)) && !out_ready |=> (st.count == (AW+1)'(DEPTH)))
    else $error("full fifo changed without a pop");

endmodule : bit_fifo

//--- core/disk_read_gate_sequencer.sv
`timescale 1ns/1ns
// Behaviour
// - Gate rise starts lock; bits after lock
// - Locking waits for servo region end
// - Gate during servo needs two-byte format lead
// - Bits valid within 11-byte preamble
// - Recovered clock toggles, locks within preamble
// - Bits held zero until first one
// - Recovered bits lag media nine bit times
// - Update leaves six-bit write splice
module disk_read_gate_sequencer (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic read_clk,
  input  wire logic read_acquire_gate,
  input  wire logic servo_region,
  input  wire logic format_write_active,
  input  wire logic media_bit,
  input  wire logic write_gate,
  output logic      recovered_bits,
  output logic      recovered_clock,
  output logic      write_splice,
  output logic      phase_locked_osc_locked
);

  localparam int LOCK_MAX_CYC = 180;

  read_gate_pkg::core_state_t cst;
  read_gate_pkg::core_state_t next_cst;
  read_gate_pkg::link_state_t lst;
  read_gate_pkg::link_state_t next_lst;

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_data;
  logic tick;
  logic pop;

  // Core domain: gate sequencing

  always_comb begin
    next_cst = cst;
    next_cst.gate_sync   = {cst.gate_sync[0], read_acquire_gate};
    next_cst.servo_sync  = {cst.servo_sync[0], servo_region};
    next_cst.format_sync = {cst.format_sync[0], format_write_active};
    next_cst.lock_sync   = {cst.lock_sync[0], lst.locked};
    if (!cst.format_sync[1]) begin
      next_cst.lead_cnt = '0;
    end else if (cst.lead_cnt != read_gate_pkg::LEAD_W'(read_gate_pkg::FORMAT_LEAD_CYCLES)) begin
      next_cst.lead_cnt = cst.lead_cnt + 1'b1;
    end
    unique case (cst.state)
      read_gate_pkg::ACQ_IDLE: begin
        next_cst.req = '0;
        if (cst.gate_sync[1]) begin
          if (cst.servo_sync[1]) begin
            next_cst.state = read_gate_pkg::ACQ_WAIT_SERVO;
          end else begin
            next_cst.state   = read_gate_pkg::ACQ_ARMED;
            next_cst.req.arm = 1'b1;
          end
        end
      end
      read_gate_pkg::ACQ_WAIT_SERVO: begin
        next_cst.req.skip_splice =
          (cst.lead_cnt == read_gate_pkg::LEAD_W'(read_gate_pkg::FORMAT_LEAD_CYCLES));
        if (!cst.gate_sync[1]) begin
          next_cst.state = read_gate_pkg::ACQ_IDLE;
          next_cst.req   = '0;
        end else if (!cst.servo_sync[1]) begin
          next_cst.state   = read_gate_pkg::ACQ_ARMED;
          next_cst.req.arm = 1'b1;
        end
      end
      read_gate_pkg::ACQ_ARMED: begin
        if (!cst.gate_sync[1]) begin
          next_cst.state = read_gate_pkg::ACQ_IDLE;
          next_cst.req   = '0;
        end
      end
      default: begin
        next_cst.state = read_gate_pkg::ACQ_IDLE;
        next_cst.req   = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cst <= '0;
    end else begin
      cst <= next_cst;
    end
  end

  assign phase_locked_osc_locked = cst.lock_sync[1];

  // Link domain: read channel on the read clock, two cycles per bit

  assign tick = !lst.phase;
  assign pop  = fifo_out_valid && lst.phase;

  bit_fifo #(
    .WIDTH (read_gate_pkg::FIFO_WIDTH),
    .DEPTH (read_gate_pkg::FIFO_DEPTH)
  ) u_bit_fifo (
    .clk       (read_clk),
    .rst       (rst),
    .in_valid  (tick),
    .in_ready  (fifo_in_ready),
    .in_data   (lst.delay_line[read_gate_pkg::DELAY_STAGES-1]),
    .out_valid (fifo_out_valid),
    .out_ready (lst.phase),
    .out_data  (fifo_out_data)
  );

  always_comb begin
    next_lst = lst;
    next_lst.media_sync = {lst.media_sync[0], media_bit};
    next_lst.wgate_sync = {lst.wgate_sync[0], write_gate};
    next_lst.arm_sync   = {lst.arm_sync[0], cst.req.arm};
    next_lst.skip_sync  = {lst.skip_sync[0], cst.req.skip_splice};
    next_lst.wgate_last = lst.wgate_sync[1];
    next_lst.arm_last   = lst.arm_sync[1];
    next_lst.phase = ~lst.phase;
    // decoder delay line, stalls with the buffer
    if (tick && fifo_in_ready) begin
      next_lst.delay_line = {lst.delay_line[read_gate_pkg::DELAY_STAGES-2:0], lst.media_sync[1]};
    end
    if (!lst.arm_sync[1]) begin
      next_lst.locked   = 1'b0;
      next_lst.lock_cnt = '0;
      next_lst.seen_one = 1'b0;
      next_lst.skip_cnt = '0;
    end else if (!lst.arm_last) begin
      next_lst.skip_cnt = lst.skip_sync[1] ? read_gate_pkg::SPLICE_W'(read_gate_pkg::SPLICE_CYCLES) : '0;
      next_lst.lock_cnt = '0;
    end else if (lst.skip_cnt != '0) begin
      next_lst.skip_cnt = lst.skip_cnt - 1'b1;
    end else if (!lst.locked && tick) begin
      if (lst.media_sync[1]) begin
        next_lst.lock_cnt = '0;
      end else if (lst.lock_cnt == read_gate_pkg::LOCK_W'(read_gate_pkg::LOCK_BITS - 1)) begin
        next_lst.locked = 1'b1;
      end else begin
        next_lst.lock_cnt = lst.lock_cnt + 1'b1;
      end
    end
    if (pop) begin
      next_lst.out_bit  = lst.locked && fifo_out_data;
      next_lst.seen_one = lst.seen_one || (lst.locked && fifo_out_data);
    end
    if (lst.wgate_sync[1] && !lst.wgate_last) begin
      next_lst.write_splice = 1'b1;
      next_lst.splice_cnt   = read_gate_pkg::SPLICE_W'(read_gate_pkg::SPLICE_CYCLES - 1);
    end else if (lst.write_splice) begin
      if (lst.splice_cnt == '0) begin
        next_lst.write_splice = 1'b0;
      end else begin
        next_lst.splice_cnt = lst.splice_cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge read_clk or posedge rst) begin
    if (rst) begin
      lst <= '0;
    end else begin
      lst <= next_lst;
    end
  end

  assign recovered_bits  = lst.out_bit;
  assign recovered_clock = lst.phase;
  assign write_splice    = lst.write_splice;

  // Checks

  sequence splice_start;
    $rose(lst.write_splice);
  endsequence

  sequence splice_span;
    ##11 lst.write_splice ##1 !lst.write_splice;
  endsequence

  property splice_width_p;
    @(posedge read_clk) disable iff (rst) splice_start |-> splice_span;
  endproperty

  splice_width_a: assert property (splice_width_p) else $error("write splice not six bits wide");

  servo_defer_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(cst.req.arm) |-> !$past(cst.servo_sync[1])) else $error("lock armed inside servo region");

  gate_arm_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(cst.req.arm) |-> $past(cst.gate_sync[1]) ##0 (cst.req.arm throughout cst.gate_sync[1] [*1]))
    else $error("lock armed without gate");

  gate_drop_a: assert property (@(posedge core_clk) disable iff (rst)
    !cst.gate_sync[1] |=> !cst.req.arm) else $error("arm held after gate drop");

  bits_locked_a: assert property (@(posedge read_clk) disable iff (rst)
    lst.out_bit && $changed(lst.out_bit) |-> $past(lst.locked)) else $error("bits out before lock");

  lock_preamble_a: assert property (@(posedge read_clk) disable iff (rst)
    $rose(lst.locked) |-> $past(lst.lock_cnt) == read_gate_pkg::LOCK_W'(read_gate_pkg::LOCK_BITS - 1)
    && (read_gate_pkg::LOCK_BITS < read_gate_pkg::PREAMBLE_BITS)) else $error("lock outside preamble");

  lock_bound_a: assert property (@(posedge read_clk) disable iff (rst)
    $rose(lst.arm_sync[1]) && !lst.skip_sync[1] ##1 (!lst.media_sync[1] && lst.arm_sync[1]) [*8]
    |-> ##[1:LOCK_MAX_CYC] (lst.locked || lst.media_sync[1] || !lst.arm_sync[1]))
    else $error("no lock within preamble");

  // First edge after release has no toggled history yet
  clock_toggle_a: assert property (@(posedge read_clk) disable iff (rst)
    !$past(rst) |-> recovered_clock != $past(recovered_clock)) else $error("recovered clock stalled");

  zero_hold_a: assert property (@(posedge read_clk) disable iff (rst)
    !lst.seen_one && !$past(lst.seen_one) |-> !lst.out_bit) else $error("one bit before sync");

  lag_nine_a: assert property (@(posedge read_clk) disable iff (rst)
    !lst.phase && lst.out_bit && $changed(lst.out_bit) |-> $past(lst.media_sync[1], 18))
    else $error("read lag not nine bit times");

  skip_splice_a: assert property (@(posedge read_clk) disable iff (rst)
    $rose(lst.arm_sync[1]) && lst.skip_sync[1] |=> (lst.lock_cnt == '0) [*8])
    else $error("locking inside servo splice");

endmodule : disk_read_gate_sequencer

//--- core/read_gate_pkg.sv
package read_gate_pkg;

  // Clock and bit timing
  localparam int CLK_PERIOD_NS      = 4;
  localparam int BIT_TIME_NS        = 160;
  localparam int BIT_CYCLES         = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int LINK_CYC_PER_BIT   = 2;

  // Format lead ahead of servo end, two bytes
  localparam int FORMAT_LEAD_BITS   = 16;
  localparam int FORMAT_LEAD_CYCLES = FORMAT_LEAD_BITS * BIT_CYCLES;
  localparam int LEAD_W             = 10;

  // Read channel
  localparam int LAG_BITS           = 9;
  localparam int DELAY_STAGES       = LAG_BITS - 1;
  localparam int PREAMBLE_BITS      = 88;
  localparam int LOCK_BITS          = 64;
  localparam int LOCK_W             = 7;

  // Write splice
  localparam int SPLICE_BITS        = 6;
  localparam int SPLICE_CYCLES      = SPLICE_BITS * LINK_CYC_PER_BIT;
  localparam int SPLICE_W           = 4;

  localparam int FIFO_WIDTH         = 1;
  localparam int FIFO_DEPTH         = 2;

  typedef enum logic [1:0] {
    ACQ_IDLE       = 2'h0,
    ACQ_WAIT_SERVO = 2'h1,
    ACQ_ARMED      = 2'h3
  } acq_state_t;

  typedef struct packed {
    logic arm;
    logic skip_splice;
  } acq_req_t;

  typedef struct packed {
    logic [1:0]        gate_sync;
    logic [1:0]        servo_sync;
    logic [1:0]        format_sync;
    logic [1:0]        lock_sync;
    acq_state_t        state;
    logic [LEAD_W-1:0] lead_cnt;
    acq_req_t          req;
  } core_state_t;

  typedef struct packed {
    logic [1:0]              media_sync;
    logic [1:0]              wgate_sync;
    logic [1:0]              arm_sync;
    logic [1:0]              skip_sync;
    logic                    wgate_last;
    logic                    arm_last;
    logic                    phase;
    logic [DELAY_STAGES-1:0] delay_line;
    logic [LOCK_W-1:0]       lock_cnt;
    logic [SPLICE_W-1:0]     skip_cnt;
    logic                    locked;
    logic                    seen_one;
    logic                    out_bit;
    logic [SPLICE_W-1:0]     splice_cnt;
    logic                    write_splice;
  } link_state_t;

endpackage : read_gate_pkg

//--- testbench/adapter_media_model.sv
`timescale 1ns/1ns
module adapter_media_model (
  input  wire logic       read_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       hold,
  input  wire logic [7:0] pat,
  output logic            gate,
  output logic            media_bit,
  output logic            done
);
  int   n;
  logic half;

  always @(negedge read_clk or posedge rst) begin
    if (rst) begin
      n         <= 0;
      half      <= 1'b0;
      gate      <= 1'b0;
      media_bit <= 1'b0;
      done      <= 1'b0;
    end else if (!start) begin
      n    <= 0;
      half <= 1'b0;
      gate <= 1'b0;
      done <= 1'b0;
    end else if (!done) begin
      gate <= 1'b1;
      half <= ~half;
      if (half && !(hold && n == 1)) begin
        n <= n + 1;
        media_bit <= (n >= 88 && n < 96) ? pat[95-n] : 1'b0;
        if (n == 111) begin
          gate <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule : adapter_media_model

//--- testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic       core_clk;
  logic       read_clk;
  logic       rst;
  logic       start;
  logic       servo;
  logic       fmt;
  logic       wgate;
  logic [7:0] pat_r;
  logic       gate;
  logic       media;
  logic       done;
  logic       rbits;
  logic       rclk;
  logic       splice;
  logic       locked;
  int         fails;
  int         checked;

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial begin
    read_clk = 1'b0;
    #7;
    forever #40 read_clk = ~read_clk;
  end

  disk_read_gate_sequencer i_disk_read_gate_sequencer (
    .core_clk(core_clk), .rst(rst), .read_clk(read_clk),
    .read_acquire_gate(gate), .servo_region(servo),
    .format_write_active(fmt), .media_bit(media), .write_gate(wgate),
    .recovered_bits(rbits), .recovered_clock(rclk),
    .write_splice(splice), .phase_locked_osc_locked(locked)
  );

  adapter_media_model i_adapter_media_model (
    .read_clk(read_clk), .rst(rst), .start(start), .hold(servo),
    .pat(pat_r), .gate(gate), .media_bit(media), .done(done)
  );

  task automatic summarize;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic expire;
    fails++;
    summarize();
  endtask : expire

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8

  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask : cmp1

  task automatic t_clk;
    logic prev;
    prev = rclk;
    repeat (8) begin
      @(negedge read_clk);
      cmp1(rclk, ~prev);
      prev = rclk;
    end
  endtask : t_clk

  // Gate released, lock must clear
  task automatic finish_read;
    int i;
    for (i = 0; i < 400 && done !== 1'b1; i++) @(negedge read_clk);
    if (done !== 1'b1) expire();
    @(negedge core_clk);
    start = 1'b0;
    fmt   = 1'b0;
    for (i = 0; i < 300 && locked !== 1'b0; i++) @(negedge core_clk);
    cmp1(locked, 1'b0);
    if (locked !== 1'b0) expire();
    repeat (4) @(negedge read_clk);
    cmp1(rbits, 1'b0);
  endtask : finish_read

  task automatic t_read(input logic [7:0] pat);
    int         i;
    int         tm;
    int         tr;
    logic [7:0] got;
    tm = -1;
    tr = -1;
    @(negedge core_clk);
    pat_r = pat;
    start = 1'b1;
    for (i = 0; i < 600 && tr < 0; i++) begin
      @(negedge read_clk);
      if (locked !== 1'b1) cmp1(rbits, 1'b0);
      if (media === 1'b1 && tm < 0) begin
        tm = i;
        cmp1(locked, 1'b1);
      end
      if (rbits === 1'b1) tr = i;
    end
    if (tr < 0) expire();
    cmp1(tr - tm >= 19 && tr - tm <= 20, 1'b1);
    for (i = 0; i < 8; i++) begin
      got[7-i] = rbits;
      repeat (2) @(negedge read_clk);
    end
    cmp8(got, pat);
    finish_read();
  endtask : t_read

  task automatic t_servo;
    int i;
    @(negedge core_clk);
    servo = 1'b1;
    fmt   = 1'b1;
    start = 1'b1;
    repeat (3000) @(negedge core_clk);
    cmp1(locked, 1'b0);
    servo = 1'b0;
    for (i = 0; i < 3600 && locked !== 1'b1; i++) @(negedge core_clk);
    cmp1(locked, 1'b1);
    if (locked !== 1'b1) expire();
    finish_read();
  endtask : t_servo

  task automatic t_splice;
    int i;
    int hi;
    hi = 0;
    @(negedge core_clk);
    wgate = 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge read_clk);
      if (splice === 1'b1) hi++;
    end
    cmp8(hi[7:0], 8'h0c);
    @(negedge core_clk);
    wgate = 1'b0;
    repeat (28) @(negedge read_clk);
  endtask : t_splice

  initial begin
    rst     = 1'b1;
    start   = 1'b0;
    servo   = 1'b0;
    fmt     = 1'b0;
    wgate   = 1'b0;
    pat_r   = 8'hb1;
    fails   = 0;
    checked = 0;
    // Long enough for both clocks to see reset
    repeat (8) @(negedge read_clk);
    cmp8({5'h00, rbits, splice, locked}, 8'h00);
    @(negedge core_clk);
    rst = 1'b0;
    t_clk();
    t_read(8'hb1);
    t_splice();
    t_splice();
    t_servo();
    t_read(8'h8d);
    summarize();
  end
endmodule : tb_top
